/* wzm_top.sv */
// The implementer's own choices: the APB slave port and the register offsets.
`include "wzm_regs.svh"

module wzm_top
  import wzm_pkg::*;
#(
  parameter int PIX_W     = 8,
  parameter int BUF_DEPTH = 4096
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  output wzm_mem_cmd_s          mem_cmd,
  output logic      [PIX_W-1:0] mem_wdata,
  output logic      [PIX_W-1:0] mem_planes,
  input  wire logic             mem_ready,
  input  wire logic [PIX_W-1:0] mem_rdata
);

  localparam int AW = $clog2(BUF_DEPTH);
  localparam int DW = PIX_W + 1;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  wzm_state_e state_q;
  logic [31:0]      ctrl_q;
  logic [PIX_W-1:0] planes_q;
  logic [PIX_W-1:0] fill_hi_q;
  logic [PIX_W-1:0] fill_lo_q;
  wzm_pt_s          ofs1_q;
  wzm_pt_s          ofs2_q;
  wzm_pt_s          win_lo_q;
  wzm_pt_s          win_hi_q;
  wzm_pt_s          centre_q;
  logic [15:0]      data_len_q;
  logic [15:0]      data_left_q;
  logic             win_set_q;
  logic             ctr_set_q;
  logic             done_q;
  logic             err_q;
  logic             wr_acc;
  logic             rd_hit;
  logic             start;
  logic             busy;
  logic             fin;

  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign busy   = (state_q != WZM_IDLE);
  assign start  = wr_acc && (paddr == `WZM_OFS_CTRL) && pwdata[`WZM_CTRL_START] && !busy;

  always_comb
  begin
    rd_hit = 1'b1;
    prdata = `WZM_RST_WORD;
    unique case (paddr)
      `WZM_OFS_CTRL:     prdata = ctrl_q;
      `WZM_OFS_STATUS:   prdata = {data_left_q, 13'h0000, err_q, done_q, busy};
      `WZM_OFS_PLANES:   prdata = 32'(planes_q);
      `WZM_OFS_FILL_HI:  prdata = 32'(fill_hi_q);
      `WZM_OFS_FILL_LO:  prdata = 32'(fill_lo_q);
      `WZM_OFS_OFFSET1:  prdata = ofs1_q;
      `WZM_OFS_OFFSET2:  prdata = ofs2_q;
      `WZM_OFS_WIN_LO:   prdata = win_lo_q;
      `WZM_OFS_WIN_HI:   prdata = win_hi_q;
      `WZM_OFS_CENTRE:   prdata = centre_q;
      `WZM_OFS_DATA_LEN: prdata = {16'h0000, data_len_q};
      `WZM_OFS_DATA:     prdata = `WZM_RST_WORD;
      default:           rd_hit = 1'b0;
    endcase
    pslverr = psel && penable && !rd_hit;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q     <= `WZM_RST_WORD;
      planes_q   <= '0;
      fill_hi_q  <= '0;
      fill_lo_q  <= '0;
      ofs1_q     <= '0;
      ofs2_q     <= '0;
      win_lo_q   <= '0;
      win_hi_q   <= '0;
      centre_q   <= '0;
      data_len_q <= '0;
    end
    else if (wr_acc)
    begin
      unique case (paddr)
        `WZM_OFS_CTRL:     ctrl_q     <= {26'h0000000, pwdata[5:1], 1'b0};
        `WZM_OFS_PLANES:   planes_q   <= pwdata[PIX_W-1:0];
        `WZM_OFS_FILL_HI:  fill_hi_q  <= pwdata[PIX_W-1:0];
        `WZM_OFS_FILL_LO:  fill_lo_q  <= pwdata[PIX_W-1:0];
        `WZM_OFS_OFFSET1:  ofs1_q     <= pwdata;
        `WZM_OFS_OFFSET2:  ofs2_q     <= pwdata;
        `WZM_OFS_WIN_LO:   win_lo_q   <= pwdata;
        `WZM_OFS_WIN_HI:   win_hi_q   <= pwdata;
        `WZM_OFS_CENTRE:   centre_q   <= pwdata;
        `WZM_OFS_DATA_LEN: data_len_q <= pwdata[15:0];
        default:           ;
      endcase
    end
  end

  // Operands written since the last start count as set in this command
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      win_set_q <= 1'b0;
      ctr_set_q <= 1'b0;
    end
    else if (start)
    begin
      win_set_q <= 1'b0;
      ctr_set_q <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (paddr == `WZM_OFS_WIN_LO || paddr == `WZM_OFS_WIN_HI)
      begin
        win_set_q <= 1'b1;
      end
      if (paddr == `WZM_OFS_CENTRE)
      begin
        ctr_set_q <= 1'b1;
      end
    end
  end

  // Trailing data words are taken and thrown away
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_left_q <= '0;
    end
    else if (start)
    begin
      data_left_q <= pwdata[`WZM_CTRL_DPRES] ? data_len_q : 16'h0000;
    end
    else if (wr_acc && paddr == `WZM_OFS_DATA && data_left_q != 16'h0000)
    begin
      data_left_q <= data_left_q - 16'h0001;
    end
  end

  // Done is set by the engine, cleared by writing one; set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_q <= 1'b0;
    end
    else if (fin)
    begin
      done_q <= 1'b1;
    end
    else if (wr_acc && paddr == `WZM_OFS_STATUS && pwdata[`WZM_ST_DONE])
    begin
      done_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Operand evaluation
  // ****************************************************************
  wzm_pt_s    off;
  wzm_coord_t wx0_q, wx1_q, wy0_q, wy1_q, cx_q, cy_q;
  wzm_coord_t ww, wh, sw_q, sh_q, sx0_q, sy0_q, sx_end, sy_end;
  logic [35:0] area;
  logic       fsel_q, fsup_q;

  function automatic wzm_coord_t addc(input logic [15:0] v, input logic [15:0] o);
    addc = wzm_coord_t'({2'b00, v}) + wzm_coord_t'({{2{o[15]}}, o});
  endfunction : addc

  always_comb
  begin
    unique case (pwdata[`WZM_CTRL_IDX_HI:`WZM_CTRL_IDX_LO])
      `WZM_IDX_FIRST:  off = ofs1_q;
      `WZM_IDX_SECOND: off = ofs2_q;
      default:         off = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wx0_q  <= '0;
      wx1_q  <= '0;
      wy0_q  <= '0;
      wy1_q  <= '0;
      cx_q   <= '0;
      cy_q   <= '0;
      fsel_q <= 1'b0;
      fsup_q <= 1'b0;
    end
    else if (start)
    begin
      wx0_q  <= addc(win_lo_q.x, win_set_q ? off.x : 16'h0000);
      wy0_q  <= addc(win_lo_q.y, win_set_q ? off.y : 16'h0000);
      wx1_q  <= addc(win_hi_q.x, win_set_q ? off.x : 16'h0000);
      wy1_q  <= addc(win_hi_q.y, win_set_q ? off.y : 16'h0000);
      cx_q   <= addc(centre_q.x, ctr_set_q ? off.x : 16'h0000);
      cy_q   <= addc(centre_q.y, ctr_set_q ? off.y : 16'h0000);
      fsel_q <= pwdata[`WZM_CTRL_FSEL];
      fsup_q <= pwdata[`WZM_CTRL_FSUP];
    end
  end

  // Centre outside the window is the host's problem, it is not checked
  assign ww     = wx1_q - wx0_q + 18'sd1;
  assign wh     = wy1_q - wy0_q + 18'sd1;
  assign area   = 36'(sw_q) * 36'(sh_q);
  assign sx_end = sx0_q + sw_q - 18'sd1;
  assign sy_end = sy0_q + sh_q - 18'sd1;

  // ****************************************************************
  // Zoom engine
  // ****************************************************************
  wzm_coord_t  sx_q, sy_q, dx_q, dy_q, wc_q;
  logic [AW-1:0] cap_idx_q, row_base_q;
  logic        px_odd_q, ln_odd_q, in_win, hs;
  logic        bwe;
  logic [DW-1:0] brd, bwd;
  logic [PIX_W-1:0] wdata_q;
  logic        wvalid_q;
  logic        too_big;

  assign in_win = (sx_q >= wx0_q) && (sx_q <= wx1_q) && (sy_q >= wy0_q) && (sy_q <= wy1_q);
  assign hs     = mem_cmd.req && mem_ready;
  // Oversized source is refused before any read reaches memory
  assign too_big = (area > 36'(BUF_DEPTH));
  // Outside pixels are stored as invalid entries instead of being read
  assign bwe    = (state_q == WZM_CAP) && (!in_win || hs);
  assign bwd    = in_win ? {1'b1, mem_rdata} : {1'b0, {PIX_W{1'b0}}};

  // Full sub-area is buffered first so in-place writes never clobber source
  wzm_src_buf #(
    .DW    (DW),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (bwe),
    .waddr   (cap_idx_q),
    .wdata   (bwd),
    .raddr   (row_base_q + wc_q[AW-1:0]),
    .rdata   (brd)
  );

  always_comb
  begin
    mem_cmd.req  = ((state_q == WZM_CAP) && in_win && !too_big)
                 || ((state_q == WZM_PUT) && (wvalid_q || !fsup_q));
    mem_cmd.we   = (state_q == WZM_PUT);
    mem_cmd.pt.x = (state_q == WZM_PUT) ? dx_q[15:0] : sx_q[15:0];
    mem_cmd.pt.y = (state_q == WZM_PUT) ? dy_q[15:0] : sy_q[15:0];
  end

  assign mem_wdata  = wdata_q;
  assign mem_planes = planes_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q    <= WZM_IDLE;
      err_q      <= 1'b0;
      fin        <= 1'b0;
      sw_q       <= '0;
      sh_q       <= '0;
      sx0_q      <= '0;
      sy0_q      <= '0;
      sx_q       <= '0;
      sy_q       <= '0;
      dx_q       <= '0;
      dy_q       <= '0;
      wc_q       <= '0;
      cap_idx_q  <= '0;
      row_base_q <= '0;
      px_odd_q   <= 1'b0;
      ln_odd_q   <= 1'b0;
      wdata_q    <= '0;
      wvalid_q   <= 1'b0;
    end
    else
    begin
      fin <= 1'b0;
      unique case (state_q)
        WZM_IDLE:
        begin
          if (start)
          begin
            err_q   <= 1'b0;
            state_q <= WZM_SETUP;
          end
        end
        WZM_SETUP:
        begin
          // Half-size source around the centre, odd sizes rounded up
          sw_q  <= (ww + 18'sd1) >>> 1;
          sh_q  <= (wh + 18'sd1) >>> 1;
          sx0_q <= cx_q - (ww >>> 2);
          sy0_q <= cy_q - (wh >>> 2);
          sx_q  <= cx_q - (ww >>> 2);
          sy_q  <= cy_q - (wh >>> 2);
          cap_idx_q <= '0;
          if (ww <= 18'sd0 || wh <= 18'sd0)
          begin
            err_q   <= 1'b1;
            fin     <= 1'b1;
            state_q <= WZM_IDLE;
          end
          else
          begin
            state_q <= WZM_CAP;
          end
        end
        WZM_CAP:
        begin
          // Buffer too small for this window: refuse rather than corrupt
          if (too_big)
          begin
            err_q   <= 1'b1;
            fin     <= 1'b1;
            state_q <= WZM_IDLE;
          end
          else if (bwe)
          begin
            cap_idx_q <= cap_idx_q + 1'b1;
            if (sx_q == sx_end)
            begin
              sx_q <= sx0_q;
              sy_q <= sy_q + 18'sd1;
              if (sy_q == sy_end)
              begin
                dx_q       <= wx0_q;
                dy_q       <= wy0_q;
                wc_q       <= '0;
                row_base_q <= '0;
                px_odd_q   <= 1'b0;
                ln_odd_q   <= 1'b0;
                state_q    <= WZM_FETCH;
              end
            end
            else
            begin
              sx_q <= sx_q + 18'sd1;
            end
          end
        end
        WZM_FETCH:
        begin
          state_q <= WZM_LOAD;
        end
        WZM_LOAD:
        begin
          wvalid_q <= brd[PIX_W];
          wdata_q  <= brd[PIX_W] ? brd[PIX_W-1:0] : (fsel_q ? fill_hi_q : fill_lo_q);
          state_q  <= WZM_PUT;
        end
        WZM_PUT:
        begin
          if (hs || !mem_cmd.req)
          begin
            state_q <= WZM_FETCH;
            // Column index advances every second pixel, row every second line
            if (dx_q == wx1_q)
            begin
              dx_q     <= wx0_q;
              wc_q     <= '0;
              px_odd_q <= 1'b0;
              dy_q     <= dy_q + 18'sd1;
              ln_odd_q <= !ln_odd_q;
              if (ln_odd_q)
              begin
                row_base_q <= row_base_q + sw_q[AW-1:0];
              end
              if (dy_q == wy1_q)
              begin
                fin     <= 1'b1;
                state_q <= WZM_IDLE;
              end
            end
            else
            begin
              dx_q     <= dx_q + 18'sd1;
              px_odd_q <= !px_odd_q;
              if (px_odd_q)
              begin
                wc_q <= wc_q + 18'sd1;
              end
            end
          end
        end
      endcase
    end
  end

endmodule : wzm_top

/* wzm_regs.svh */
// ****************************************************************
// Summary of operation
// ****************************************************************
// Summary of operation
// - Zoom by two in both dimensions, inside window.
// - Each source pixel becomes one two-by-two block.
// - Centre point lands at the window centre.
// - Source is half-size rectangle around centre point.
// - Never read source pixels outside the window.
// - Missing source filled low value or high value.
// - Fill suppress leaves missing pixels unwritten.
// - Index mode steers operand addressing.
// - Mode 01 adds first offset, 02 second.
// - Only selected planes are written.
// - Result written back into the same window.
// - Trailing data words accepted and discarded.
`ifndef WZM_REGS_SVH
`define WZM_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define WZM_OFS_CTRL     12'h000
`define WZM_OFS_STATUS   12'h004
`define WZM_OFS_PLANES   12'h008
`define WZM_OFS_FILL_HI  12'h00c
`define WZM_OFS_FILL_LO  12'h010
`define WZM_OFS_OFFSET1  12'h014
`define WZM_OFS_OFFSET2  12'h018
`define WZM_OFS_WIN_LO   12'h01c
`define WZM_OFS_WIN_HI   12'h020
`define WZM_OFS_CENTRE   12'h024
`define WZM_OFS_DATA_LEN 12'h028
`define WZM_OFS_DATA     12'h02c

// ****************************************************************
// Field positions
// ****************************************************************
`define WZM_CTRL_START   0
`define WZM_CTRL_FSEL    1
`define WZM_CTRL_FSUP    2
`define WZM_CTRL_IDX_LO  3
`define WZM_CTRL_IDX_HI  4
`define WZM_CTRL_DPRES   5
`define WZM_ST_BUSY      0
`define WZM_ST_DONE      1
`define WZM_ST_ERR       2
`define WZM_ST_LEFT_LO   16

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define WZM_RST_WORD     32'h0000_0000
`define WZM_IDX_FIRST    2'h1
`define WZM_IDX_SECOND   2'h2

`endif

/* wzm_pkg.sv */
package wzm_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [5:0] {
    WZM_IDLE  = 6'h01,
    WZM_SETUP = 6'h02,
    WZM_CAP   = 6'h04,
    WZM_FETCH = 6'h08,
    WZM_LOAD  = 6'h10,
    WZM_PUT   = 6'h20
  } wzm_state_e;

  typedef struct packed {
    logic [15:0] y;
    logic [15:0] x;
  } wzm_pt_s;

  typedef struct packed {
    logic req;
    logic we;
    wzm_pt_s pt;
  } wzm_mem_cmd_s;

  typedef logic signed [17:0] wzm_coord_t;

endpackage : wzm_pkg

/* wzm_src_buf.sv */
module wzm_src_buf #(
  parameter int DW    = 9,
  parameter int DEPTH = 4096,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  // No reset on the array so it maps onto block memory
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end

endmodule : wzm_src_buf

/* wzm_mem_model.sv */
module wzm_mem_model
  import wzm_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         stall,
  input  wire wzm_mem_cmd_s mem_cmd,
  input  wire logic [7:0]   mem_wdata,
  input  wire logic [7:0]   mem_planes,
  output logic              mem_ready,
  output logic [7:0]        mem_rdata
);
  // ****
  // Pixel store, 16 by 16
  // ****
  logic [7:0] pix [256];
  logic [7:0] last_q;
  logic       wait_q;
  logic [7:0] at;
  assign at = {mem_cmd.pt.y[3:0], mem_cmd.pt.x[3:0]};
  // Slow mode holds every request one extra cycle
  assign mem_ready = mem_cmd.req && (!stall || wait_q);
  // Off a read handshake the bus toggles, so stale data never looks valid
  assign mem_rdata = (mem_ready && !mem_cmd.we) ? pix[at] : ~last_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_q <= 1'h0;
      last_q <= 8'h00;
      for (int k = 0; k < 256; k++)
        pix[k] <= 8'(k * 29 + 7);
    end
    else
    begin
      wait_q <= mem_cmd.req && !mem_ready;
      last_q <= mem_rdata;
      if (mem_ready && mem_cmd.we)
        pix[at] <= (pix[at] & ~mem_planes) | (mem_wdata & mem_planes);
    end
  end
endmodule : wzm_mem_model

/* wzm_checker.sv */
module wzm_checker
  import wzm_pkg::*;
#(
  parameter int PIX_W = 8
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pslverr,
  input wire wzm_mem_cmd_s     mem_cmd,
  input wire logic [PIX_W-1:0] mem_wdata,
  input wire logic [PIX_W-1:0] mem_planes,
  input wire logic             mem_ready
);
  // ****
  // Helpers
  // ****
  logic acc, whs, bad, start, wrote_q, first_q, x0p_q;
  logic [15:0] px_q, py_q;
  logic [PIX_W-1:0] pd_q, pl_q;
  assign acc = psel && penable;
  assign whs = mem_cmd.req && mem_ready && mem_cmd.we;
  assign bad = paddr > 12'h02c || paddr[1:0] != 2'h0;
  assign start = acc && pwrite && paddr == 12'h000 && pwdata[0];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wrote_q <= 1'h0;
      first_q <= 1'h1;
    end
    else if (start)
    begin
      wrote_q <= 1'h0;
      first_q <= 1'h1;
    end
    else if (whs)
    begin
      wrote_q <= 1'h1;
      first_q <= 1'h0;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pl_q <= '0;
    else if (acc && pwrite && paddr == 12'h008)
      pl_q <= pwdata[PIX_W-1:0];
  end
  // Only x parity of the window origin matters; skipped fills come in pairs
  always_ff @(posedge pclk)
  begin
    if (whs)
    begin
      px_q <= mem_cmd.pt.x;
      py_q <= mem_cmd.pt.y;
      pd_q <= mem_wdata;
      if (first_q)
        x0p_q <= mem_cmd.pt.x[0];
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_unmapped_err: assert property (acc && bad |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && !bad |-> !pslverr)
    else $error("mapped access refused");
  a_req_stands: assert property (mem_cmd.req && !mem_ready |=>
    $stable(mem_cmd) && $stable(mem_wdata)) else $error("request moved before ready");
  a_reads_first: assert property (mem_cmd.req && !mem_cmd.we |-> !wrote_q)
    else $error("read after a write");
  a_pair_equal: assert property (whs && !first_q && mem_cmd.pt.y == py_q
    && mem_cmd.pt.x == 16'(px_q + 16'h1) && mem_cmd.pt.x[0] != x0p_q |-> mem_wdata == pd_q)
    else $error("pixel pair differs");
  a_rows_ordered: assert property (whs && !first_q |-> mem_cmd.pt.y > py_q
    || (mem_cmd.pt.y == py_q && mem_cmd.pt.x > px_q)) else $error("write order broken");
  a_planes_used: assert property (mem_cmd.req && mem_cmd.we |-> mem_planes == pl_q)
    else $error("plane mask wrong");
  a_busy_seen: assert property (acc && !pwrite && paddr == 12'h004 && mem_cmd.req
    |-> prdata[0]) else $error("busy not shown");
  a_start_clears: assert property (acc && !pwrite && paddr == 12'h000 |-> !prdata[0])
    else $error("start reads one");
  c_write: cover property (whs);
  c_read: cover property (mem_cmd.req && mem_ready && !mem_cmd.we);
  c_refused: cover property (acc && pslverr);
endmodule : wzm_checker

bind wzm_top wzm_checker #(.PIX_W(PIX_W)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .mem_cmd(mem_cmd), .mem_wdata(mem_wdata), .mem_planes(mem_planes), .mem_ready(mem_ready)
);

/* test_window_pixel_magnifier.sv */
module test_window_pixel_magnifier
  import wzm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err, mem_ready, stall;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [7:0]   mem_wdata, mem_planes, mem_rdata;
  wzm_mem_cmd_s mem_cmd;
  logic [7:0]   ref_q [256];
  int           mismatches, checked;

  wzm_top #(.PIX_W(8), .BUF_DEPTH(64)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_cmd(mem_cmd), .mem_wdata(mem_wdata), .mem_planes(mem_planes),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata)
  );
  wzm_mem_model mem_u (
    .pclk(pclk), .presetn(presetn), .stall(stall), .mem_cmd(mem_cmd),
    .mem_wdata(mem_wdata), .mem_planes(mem_planes), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata)
  );

  initial
  begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end

  // ****
  // Tasks
  // ****
  task automatic complete_run();
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  // Starts one edge late so back-to-back calls never rewrite psel in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge pclk);
      if (pready === 1'h1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n == 50)
    begin
      mismatches++;
      complete_run();
    end
  endtask : apb

  task automatic wait_done();
    int n;
    for (n = 0; n < 3000; n++)
    begin
      apb(1'h0, 12'h004, 32'h0);
      if (rd[1] === 1'h1)
        break;
    end
    if (n == 3000)
    begin
      mismatches++;
      complete_run();
    end
  endtask : wait_done

  function automatic void expect_zoom(input int x0, y0, x1, y1, cx, cy, fs, fu,
                                      input logic [7:0] pl, hi, lo);
    logic [7:0] src [256];
    logic [7:0] v;
    int sx, sy;
    src = ref_q;
    for (int y = y0; y <= y1; y++)
    begin
      for (int x = x0; x <= x1; x++)
      begin
        sx = cx - (x1 - x0 + 1) / 4 + (x - x0) / 2;
        sy = cy - (y1 - y0 + 1) / 4 + (y - y0) / 2;
        v = fs ? hi : lo;
        if (sx >= x0 && sx <= x1 && sy >= y0 && sy <= y1)
          v = src[sy * 16 + sx];
        else if (fu)
          continue;
        ref_q[y * 16 + x] = (ref_q[y * 16 + x] & ~pl) | (v & pl);
      end
    end
  endfunction : expect_zoom

  // ****
  // Main sequence
  // ****
  initial
  begin
    logic [31:0] o1, o2, off;
    logic [7:0] pl, hi, lo;
    int x0, y0, x1, y1, cx, cy, md, fs, fu, dp;
    {presetn, psel, penable, pwrite, stall} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    mismatches = 0;
    checked = 0;
    void'($urandom(91));
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 12'h000, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'h0, 12'h004, 32'h0);
    chk("status", 32'h0, rd);
    apb(1'h1, 12'h030, $urandom);
    chk("wr refused", 32'h1, err);
    apb(1'h0, 12'h031, 32'h0);
    chk("rd refused", 32'h1, err);
    for (int k = 0; k < 256; k++)
      ref_q[k] = mem_u.pix[k];
    for (int i = 0; i < 8; i++)
    begin
      md = i % 4;
      fs = i % 2;
      fu = (i == 5);
      dp = i / 4;
      stall <= (i / 2) % 2 == 1;
      o1 = $urandom & 32'h0003_0003;
      o2 = $urandom & 32'h0003_0003;
      x0 = $urandom % 4;
      y0 = $urandom % 4;
      x1 = x0 + 3 + $urandom % 6;
      y1 = y0 + 3 + $urandom % 6;
      // Centre kept inside the window, on an edge or in the middle
      cx = (i % 3 == 0) ? x0 : ((i % 3 == 1) ? x1 : (x0 + x1) / 2);
      cy = (i % 2 == 1) ? y1 : (y0 + y1) / 2;
      pl = (i % 2 == 1) ? 8'($urandom) : 8'hff;
      hi = 8'($urandom);
      lo = 8'($urandom);
      apb(1'h1, 12'h008, {24'h0, pl});
      apb(1'h1, 12'h00c, {24'h0, hi});
      apb(1'h1, 12'h010, {24'h0, lo});
      apb(1'h1, 12'h014, o1);
      apb(1'h1, 12'h018, o2);
      apb(1'h1, 12'h01c, {16'(y0), 16'(x0)});
      apb(1'h1, 12'h020, {16'(y1), 16'(x1)});
      apb(1'h1, 12'h024, {16'(cy), 16'(cx)});
      apb(1'h1, 12'h028, 32'(i));
      apb(1'h1, 12'h000, 32'(dp * 32 + md * 8 + fu * 4 + fs * 2 + 1));
      off = (md == 1) ? o1 : ((md == 2) ? o2 : 32'h0);
      expect_zoom(x0 + off[15:0], y0 + off[31:16], x1 + off[15:0], y1 + off[31:16],
                  cx + off[15:0], cy + off[31:16], fs, fu, pl, hi, lo);
      apb(1'h0, 12'h000, 32'h0);
      chk("ctrl", 32'(dp * 32 + md * 8 + fu * 4 + fs * 2), rd);
      apb(1'h0, 12'h004, 32'h0);
      chk("left", 32'(dp * i), {16'h0, rd[31:16]});
      repeat (dp * i) apb(1'h1, 12'h02c, $urandom);
      apb(1'h0, 12'h004, 32'h0);
      chk("left", 32'h0, {16'h0, rd[31:16]});
      wait_done();
      chk("error", 32'h0, {31'h0, rd[2]});
      apb(1'h1, 12'h004, 32'h2);
      for (int k = 0; k < 256; k++)
        chk("pixel", {24'h0, ref_q[k]}, {24'h0, mem_u.pix[k]});
    end
    // Inverted and oversized windows are refused and leave memory alone
    for (int j = 0; j < 2; j++)
    begin
      apb(1'h1, 12'h01c, (j == 0) ? 32'h0000_0005 : 32'h0000_0000);
      apb(1'h1, 12'h020, (j == 0) ? 32'h0003_0002 : 32'h0011_000f);
      apb(1'h1, 12'h000, 32'h0000_0001);
      wait_done();
      chk("error", 32'h1, {31'h0, rd[2]});
      apb(1'h1, 12'h004, 32'h2);
      for (int k = 0; k < 256; k++)
        chk("pixel", {24'h0, ref_q[k]}, {24'h0, mem_u.pix[k]});
    end
    complete_run();
  end
endmodule : test_window_pixel_magnifier
